//--- src/eiec_top.sv
// control and status registers of the external interrupt edge control block
//
// Summary of operation
// - line four: 1 falling edge, 0 rising
// - line three: 1 falling edge, 0 rising
// - bits 4 and 3 are real R/W bits
// - five R/W edge selects, bits 4..0, reset 0
// - bits 13..5 of edge register read zero
// - trap flags at bits 4..1, cleared at reset
//
// notes for whoever picks this block up next
// - pins reach the logic through two flops, so a pin pulse
//   shorter than one clock may be lost
// - edge detection is held off for a few clocks after reset: the
//   synchroniser is still flushing then, and a pin that rests high
//   through reset would otherwise look like a fresh rising edge
// - a real pin change in those first clocks is lost as well; that
//   is the price of never raising a false interrupt at start-up
// - changing a polarity select while a pin is quiet raises nothing,
//   because the detector compares two sampled levels only
// - trap flags are cleared by writing zero to them, while the
//   status bits behind irq_o are cleared by writing one
// - a hardware event and a software clear in the same cycle leave
//   the flag set, so a clear never drops an event
// - the read port never stalls: read data stand for exactly one
//   cycle after the strobe and read zero otherwise
module eiec_top (
   // one clock, synchronous active-high reset
   input wire logic clock_i,
   input wire logic rst_i,
   // register port: byte address, write data, one-cycle strobes
   input wire logic [15:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   // external interrupt pins, asynchronous, line n at bit n
   input wire logic [eiec_pkg::EIEC_LINES-1:0] ext_irq_i,
   // trap pulses and disable status from the core, same clock
   input wire logic trap_arith_i,
   input wire logic trap_address_i,
   input wire logic trap_stack_i,
   input wire logic trap_osc_i,
   input wire logic irq_disable_active_i,
   // read data, interrupt outputs and control bits, all registered
   output logic [15:0] rdata_o,
   output logic irq_o,
   output logic [eiec_pkg::EIEC_LINES-1:0] line_irq_o,
   output logic nesting_disable_o,
   output logic alternate_vector_sel_o
);
   localparam int N = eiec_pkg::EIEC_LINES;
   // trap flag bits 4..1, which a written zero clears and a written one leaves alone
   localparam logic [15:0] TRAP_FLAGS = (16'h0001 << eiec_pkg::EIEC_ARITH_ERROR_BIT)
      | (16'h0001 << eiec_pkg::EIEC_ADDRESS_ERROR_BIT)
      | (16'h0001 << eiec_pkg::EIEC_STACK_ERROR_BIT)
      | (16'h0001 << eiec_pkg::EIEC_OSC_FAILURE_BIT);
   // clocks after reset before an edge is believed: both synchroniser
   // stages, the detector's previous level and its output flop
   localparam int WARM_CLOCKS = eiec_pkg::EIEC_SYNC_STAGES + 2;

   // whole state of the block
   typedef struct packed {
      // software registers
      logic [15:0] trap_status_control; // nesting disable and trap flags
      logic [15:0] edge_polarity_control; // vector select, disable status, edge selects
      logic [N-1:0] irq_status; // sticky edge events, write one to clear
      logic [N-1:0] irq_mask; // a one lets the line onto irq_o
      // registered outputs
      logic [15:0] rdata; // read data, one cycle after the strobe
      logic irq; // level interrupt
      logic [N-1:0] line_irq; // per-line edge pulse
      // start-up guard
      logic [2:0] warm; // clocks since reset, stops at WARM_CLOCKS
   } eiec_state_t;

   eiec_state_t state_reg; // registered state
   eiec_state_t state_next; // next value of the whole state
   eiec_pkg::eiec_req_t req; // register port request bundle
   eiec_pkg::eiec_trap_t trap; // trap event bundle
   logic [N-1:0] line_sync; // synchronised pin levels
   logic [N-1:0] line_edge; // one-cycle edge pulses
   logic [N-1:0] edge_sel; // per-line falling select
   logic edges_valid; // detector path holds real pin samples
   logic [N-1:0] edge_seen; // edge pulses once the path is warm

   assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
   assign trap = '{arith: trap_arith_i, address: trap_address_i, stack: trap_stack_i, osc: trap_osc_i};

   // merge a write into a register, keeping read-only bits
   function automatic logic [15:0] eiec_merge(input logic [15:0] old, input logic [15:0] wd,
                                              input logic [15:0] wmask);
      eiec_merge = (old & ~wmask) | (wd & wmask);
   endfunction

   // widen a per-line vector to a register word; upper bits read zero
   function automatic logic [15:0] eiec_zext(input logic [N-1:0] v);
      eiec_zext = {{(16-N){1'b0}}, v};
   endfunction

   // pins are asynchronous, so two flops before any logic
   eiec_sync #(.WIDTH(N)) u_sync (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .async_i(ext_irq_i),
      .sync_o(line_sync)
   );

   // polarity selects for all five lines share one encoding
   assign edge_sel = state_reg.edge_polarity_control[eiec_pkg::EIEC_EDGE_SEL_LSB +: N];

   eiec_edge_detect #(.WIDTH(N)) u_edge (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .level_i(line_sync),
      .falling_sel_i(edge_sel),
      .edge_o(line_edge)
   );

   // the synchroniser flushes to zero at reset, so a pin resting high
   // would look like a rising edge; pulses wait until the path is warm
   assign edges_valid = (state_reg.warm == 3'(WARM_CLOCKS));
   assign edge_seen = line_edge & {N{edges_valid}};

   // register writes, sticky flags, read mux
   always_comb
   begin
      state_next = state_reg;
      // software write: only implemented bits change
      if (req.wr)
      begin
         unique case (req.addr)
            eiec_pkg::EIEC_TRAP_STATUS_CONTROL_OFS:
            begin
               // trap flags are set by hardware, cleared by writing zero
               state_next.trap_status_control = eiec_merge(state_reg.trap_status_control, req.wdata,
                                                           eiec_pkg::EIEC_TRAP_WMASK)
                  & ~(~req.wdata & TRAP_FLAGS);
            end
            eiec_pkg::EIEC_EDGE_POLARITY_CONTROL_OFS:
            begin
               // bits 15 and 4..0 writable, 13..5 stay zero
               state_next.edge_polarity_control = eiec_merge(state_reg.edge_polarity_control, req.wdata,
                                                             eiec_pkg::EIEC_EDGE_WMASK);
            end
            eiec_pkg::EIEC_IRQ_STATUS_OFS:
            begin
               // write one to clear
               state_next.irq_status = state_reg.irq_status & ~req.wdata[N-1:0];
            end
            eiec_pkg::EIEC_IRQ_MASK_OFS:
            begin
               state_next.irq_mask = req.wdata[N-1:0];
            end
            default:
            begin
               // unmapped or read-only: ignored
            end
         endcase
      end
      // trap events set after any clear, so set wins
      if (trap.arith)
      begin
         state_next.trap_status_control[eiec_pkg::EIEC_ARITH_ERROR_BIT] = 1'b1;
      end
      if (trap.address)
      begin
         state_next.trap_status_control[eiec_pkg::EIEC_ADDRESS_ERROR_BIT] = 1'b1;
      end
      if (trap.stack)
      begin
         state_next.trap_status_control[eiec_pkg::EIEC_STACK_ERROR_BIT] = 1'b1;
      end
      if (trap.osc)
      begin
         state_next.trap_status_control[eiec_pkg::EIEC_OSC_FAILURE_BIT] = 1'b1;
      end
      // read-only disable status mirrors the core
      state_next.edge_polarity_control[eiec_pkg::EIEC_IRQ_DISABLE_BIT] = irq_disable_active_i;
      // count clocks after reset until the detector path is trustworthy
      if (!edges_valid)
      begin
         state_next.warm = state_reg.warm + 3'h1;
      end
      // edge events set sticky status, set beats clear
      state_next.irq_status = state_next.irq_status | edge_seen;
      state_next.line_irq = edge_seen;
      // level interrupt from unmasked status
      state_next.irq = |(state_next.irq_status & state_next.irq_mask);
      // read data stand only in the cycle after the strobe
      state_next.rdata = 16'h0000;
      if (req.rd)
      begin
         unique case (req.addr)
            eiec_pkg::EIEC_TRAP_STATUS_CONTROL_OFS:
            begin
               state_next.rdata = state_reg.trap_status_control;
            end
            eiec_pkg::EIEC_EDGE_POLARITY_CONTROL_OFS:
            begin
               state_next.rdata = state_reg.edge_polarity_control;
            end
            eiec_pkg::EIEC_IRQ_STATUS_OFS:
            begin
               // sticky events, including masked lines
               state_next.rdata = eiec_zext(state_reg.irq_status);
            end
            eiec_pkg::EIEC_IRQ_MASK_OFS:
            begin
               // enables of the level interrupt
               state_next.rdata = eiec_zext(state_reg.irq_mask);
            end
            eiec_pkg::EIEC_LINE_LEVEL_OFS:
            begin
               // pin levels after the synchroniser, two clocks old
               state_next.rdata = eiec_zext(line_sync);
            end
            default:
            begin
               // unmapped reads return zero
               state_next.rdata = 16'h0000;
            end
         endcase
      end
   end

   // register the copy; all registers clear on reset
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         state_reg.trap_status_control <= eiec_pkg::EIEC_TRAP_RESET;
         state_reg.edge_polarity_control <= eiec_pkg::EIEC_EDGE_RESET;
         state_reg.irq_status <= '0;
         state_reg.irq_mask <= '0;
         state_reg.rdata <= 16'h0000;
         state_reg.irq <= 1'b0;
         state_reg.line_irq <= '0;
         // start the warm-up count again after every reset
         state_reg.warm <= 3'h0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // outputs straight from flops; no logic between the state and the
   // pins, so the core sees clean levels at the start of every cycle
   assign rdata_o = state_reg.rdata;
   assign irq_o = state_reg.irq;
   assign line_irq_o = state_reg.line_irq;
   assign nesting_disable_o = state_reg.trap_status_control[eiec_pkg::EIEC_NESTING_DISABLE_BIT];
   assign alternate_vector_sel_o = state_reg.edge_polarity_control[eiec_pkg::EIEC_ALTERNATE_VECTOR_BIT];
endmodule

//--- shared/eiec_pkg.sv
// package of register map, field positions and carrier types for the external interrupt edge control block
package eiec_pkg;
   // register offsets (byte addresses on the plain register port)
   localparam logic [15:0] EIEC_TRAP_STATUS_CONTROL_OFS = 16'h0080;
   localparam logic [15:0] EIEC_EDGE_POLARITY_CONTROL_OFS = 16'h0082;
   localparam logic [15:0] EIEC_IRQ_STATUS_OFS = 16'h0084;
   localparam logic [15:0] EIEC_IRQ_MASK_OFS = 16'h0086;
   localparam logic [15:0] EIEC_LINE_LEVEL_OFS = 16'h0088;
   // reset values
   localparam logic [15:0] EIEC_TRAP_RESET = 16'h0000;
   localparam logic [15:0] EIEC_EDGE_RESET = 16'h0000;
   localparam logic [15:0] EIEC_IRQ_RESET = 16'h0000;
   // trap_status_control fields
   localparam int EIEC_NESTING_DISABLE_BIT = 15;
   localparam int EIEC_ARITH_ERROR_BIT = 4;
   localparam int EIEC_ADDRESS_ERROR_BIT = 3;
   localparam int EIEC_STACK_ERROR_BIT = 2;
   localparam int EIEC_OSC_FAILURE_BIT = 1;
   // edge_polarity_control fields
   localparam int EIEC_ALTERNATE_VECTOR_BIT = 15;
   localparam int EIEC_IRQ_DISABLE_BIT = 14;
   localparam int EIEC_EDGE_SEL_LSB = 0;
   localparam int EIEC_LINES = 5;
   // writable masks
   localparam logic [15:0] EIEC_TRAP_WMASK = 16'h8000;
   localparam logic [15:0] EIEC_EDGE_WMASK = 16'h801F;
   localparam logic [15:0] EIEC_STATUS_WMASK = 16'h001F;
   // synchroniser depth
   localparam int EIEC_SYNC_STAGES = 2;

   // register port request
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } eiec_req_t;

   // trap event pulses from the core
   typedef struct packed {
      logic arith;
      logic address;
      logic stack;
      logic osc;
   } eiec_trap_t;
endpackage

//--- src/eiec_sync.sv
// two-stage synchroniser bank for the external interrupt pins
module eiec_sync #(
   parameter int WIDTH = 5
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   // state: first and second stage
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } eiec_sync_state_t;

   eiec_sync_state_t state_reg;
   eiec_sync_state_t state_next;

   // first stage feeds only the second stage
   always_comb
   begin
      state_next = state_reg;
      state_next.meta = async_i;
      state_next.stable = state_reg.meta;
   end

   // register the copy
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign sync_o = state_reg.stable;
endmodule

//--- src/eiec_edge_detect.sv
// per-line edge detector with selectable polarity
module eiec_edge_detect #(
   parameter int WIDTH = 5
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] level_i,
   input wire logic [WIDTH-1:0] falling_sel_i,
   output logic [WIDTH-1:0] edge_o
);
   // state: previous level and detected edge pulse
   typedef struct packed {
      logic [WIDTH-1:0] prev;
      logic [WIDTH-1:0] hit;
   } eiec_edge_state_t;

   eiec_edge_state_t state_reg;
   eiec_edge_state_t state_next;

   // select 1 picks high-to-low, 0 picks low-to-high
   always_comb
   begin
      state_next = state_reg;
      state_next.prev = level_i;
      state_next.hit = (falling_sel_i & state_reg.prev & ~level_i)
         | (~falling_sel_i & ~state_reg.prev & level_i);
   end

   // register the copy
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign edge_o = state_reg.hit;
endmodule

//--- verif/eiec_pin_model.sv
// behavioural model of the five external interrupt pins
module eiec_pin_model (
   input wire logic clock_i,
   input wire logic [4:0] level_i,
   output logic [4:0] pin_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // pins are push-pull levels; they move one cycle after the command
   always @(posedge clock_i)
   begin
      pin_o <= level_i;
   end
   initial pin_o = 5'h00;
endmodule

//--- verif/eiec_chk.sv
// assertion checker for the external interrupt edge control block
module eiec_chk (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [15:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [eiec_pkg::EIEC_LINES-1:0] ext_irq_i,
   input wire logic trap_arith_i,
   input wire logic trap_osc_i,
   input wire logic [15:0] rdata_o,
   input wire logic [eiec_pkg::EIEC_LINES-1:0] line_irq_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] sel_reg; // shadow of the polarity selects
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   // follow writes so edge checks need no probe into the design
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         sel_reg <= 5'h00;
      else if (wr_i && addr_i == 16'h0082)
         sel_reg <= wdata_i[4:0];
   end
   sequence s_sel_wr;
      wr_i && addr_i == 16'h0082;
   endsequence
   sequence s_sel_rd;
      rd_i && addr_i == 16'h0082;
   endsequence
   a_sel_read_back: assert property (s_sel_wr ##1 s_sel_rd |=> rdata_o[4:0] == $past(wdata_i[4:0], 2))
      else $error("select readback differs");
   a_gap_reads_zero: assert property (s_sel_rd |=> rdata_o[13:5] == 9'h000)
      else $error("unimplemented bits not zero");
   a_arith_flag_set: assert property (trap_arith_i ##1 (rd_i && addr_i == 16'h0080) |=> rdata_o[4])
      else $error("arith flag missing");
   a_osc_flag_set: assert property (trap_osc_i ##1 (rd_i && addr_i == 16'h0080) |=> rdata_o[1])
      else $error("osc flag missing");
   a_reset_quiet: assert property ($fell(rst_i) |-> rdata_o == 16'h0000 && line_irq_o == 5'h00)
      else $error("outputs busy after reset");
   // a pin resting high through reset must not look like a fresh edge
   a_quiet_after_reset: assert property ($fell(rst_i) |-> (line_irq_o == 5'h00) [*5])
      else $error("edge pulse right after reset");
   // a pin edge takes up to six edges through synchroniser and detector
   for (genvar k = 0; k < 5; k++)
   begin : g_line
      a_edge_hit: assert property ($changed(ext_irq_i[k]) && ext_irq_i[k] != sel_reg[k] |-> ##[2:6] line_irq_o[k])
         else $error("selected edge not detected");
      a_edge_miss: assert property ($changed(ext_irq_i[k]) && ext_irq_i[k] == sel_reg[k] |-> ##1 !line_irq_o[k] [*6])
         else $error("wrong edge detected");
   end
endmodule
bind eiec_top eiec_chk i_eiec_chk (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .ext_irq_i(ext_irq_i), .trap_arith_i(trap_arith_i), .trap_osc_i(trap_osc_i),
   .rdata_o(rdata_o), .line_irq_o(line_irq_o));

//--- verif/tb_top.sv
// self-checking testbench for the external interrupt edge control block
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic [15:0] addr_i = 16'h0000, wdata_i = 16'h0000, rdata_o, mask = 16'h001F, e;
   logic wr_i = 1'b0, rd_i = 1'b0, dis = 1'b0, irq_o, nest_o, alt_o;
   logic [3:0] trap = 4'h0; // arith, address, stack, osc
   logic [4:0] want = 5'h00, pins, line_irq;
   int fails = 0, check_count = 0, hits;
   always #50 clock_i = ~clock_i;
   eiec_pin_model i_eiec_pin_model (.clock_i(clock_i), .level_i(want), .pin_o(pins));
   eiec_top i_eiec_top (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .ext_irq_i(pins), .trap_arith_i(trap[3]), .trap_address_i(trap[2]), .trap_stack_i(trap[1]),
      .trap_osc_i(trap[0]), .irq_disable_active_i(dis), .rdata_o(rdata_o), .irq_o(irq_o),
      .line_irq_o(line_irq), .nesting_disable_o(nest_o), .alternate_vector_sel_o(alt_o));
   task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // one-cycle write; a strobe still pending from the last write gets its own edge first
   task wr(input logic [15:0] a, input logic [15:0] d);
      if (wr_i === 1'b1)
         @(posedge clock_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task rd(input string name, input logic [15:0] a, input logic [15:0] exp);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 check(name, rdata_o, exp);
      @(posedge clock_i);
   endtask
   // trap event, then read the flags straight away
   task trap_read(input logic [3:0] t, input logic [15:0] exp);
      trap <= t;
      @(posedge clock_i);
      trap <= 4'h0;
      rd("trap flags", 16'h0080, exp);
   endtask
   // move one pin, count pulses in a window longer than the sync path, then read status and clear it for an unmasked line
   task pin(input int k, input logic lvl, input logic hit);
      want[k] <= lvl;
      hits = 0;
      repeat (12)
      begin
         @(posedge clock_i);
         #1 hits += (line_irq[k] === 1'b1);
      end
      check("pulse count", 16'(hits), {15'h0000, hit});
      check("irq level", {15'h0000, irq_o}, {15'h0000, hit & mask[k]});
      @(posedge clock_i);
      rd("status", 16'h0084, 16'(hit) << k);
      // a masked line keeps its status so that unmasking can be checked
      if (hit && mask[k])
         wr(16'h0084, 16'h0001 << k);
   endtask
   initial
   begin
      repeat (6) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      rd("trap reset", 16'h0080, 16'h0000);
      rd("edge reset", 16'h0082, 16'h0000);
      // only real bits stick, the gap reads zero
      wr(16'h0082, 16'hFFFF);
      rd("edge ones", 16'h0082, 16'h801F);
      check("alt vector", {15'h0000, alt_o}, 16'h0001);
      dis <= 1'b1;
      wr(16'h0082, 16'h0018);
      rd("edge four three", 16'h0082, 16'h4018);
      e = 16'h0000;
      for (int i = 3; i >= 0; i--)
      begin
         e = e | (16'h0002 << i);
         trap_read(4'h1 << i, e);
      end
      // writing zero clears the flags while bit 15 sets
      wr(16'h0080, 16'h8000);
      rd("trap cleared", 16'h0080, 16'h8000);
      check("nesting", {15'h0000, nest_o}, 16'h0001);
      rd("unmapped", 16'h0090, 16'h0000);
      wr(16'h0088, 16'hFFFF);
      rd("pin levels", 16'h0088, 16'h0000);
      wr(16'h0086, mask);
      // every line with both select codes, wanted and unwanted edges
      for (int k = 0; k < 5; k++)
      begin
         wr(16'h0082, 16'h0000);
         pin(k, 1'b1, 1'b1);
         pin(k, 1'b0, 1'b0);
         wr(16'h0082, 16'h0001 << k);
         pin(k, 1'b1, 1'b0);
         pin(k, 1'b0, 1'b1);
      end
      // masked line sets status only; unmasking then raises the output
      mask = 16'h001E;
      wr(16'h0082, 16'h0000);
      wr(16'h0086, mask);
      pin(0, 1'b1, 1'b1);
      rd("pin levels high", 16'h0088, 16'h0001);
      mask = 16'h001F;
      wr(16'h0086, mask);
      @(posedge clock_i);
      #1 check("irq unmasked", {15'h0000, irq_o}, 16'h0001);
      wr(16'h0084, 16'h0001);
      @(posedge clock_i);
      #1 check("irq cleared", {15'h0000, irq_o}, 16'h0000);
      // reset with pin zero still high: no false edge may follow
      dis <= 1'b0;
      rst_i <= 1'b1;
      repeat (6) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      rd("edge after reset", 16'h0082, 16'h0000);
      repeat (2) @(posedge clock_i);
      rd("status after reset", 16'h0084, 16'h0000);
      summarize;
   end
   // watchdog: a hang counts as a mismatch
   initial
   begin
      repeat (20000) @(posedge clock_i);
      fails++;
      summarize;
   end
endmodule
